//--- rtl/aux_control_register.sv
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
// auxiliary control register with input-change interrupt and counter/timer source steering
module aux_control_register
    import aux_control_pkg::*;
#(
    parameter int pin_count = 4,
    parameter logic [15:0] ct_preload = 16'h0010 // counter/timer reload value
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic reset_in,
    // register port
    input wire logic [3:0] address_in,
    input wire logic [7:0] write_data_in,
    input wire logic write_strobe_in,
    input wire logic read_strobe_in,
    output logic [7:0] read_data_out,
    // input pins (asynchronous)
    input wire logic [pin_count-1:0] input_pin_in,
    input wire logic chan_a_tx_1x_clock_in,
    input wire logic chan_b_tx_1x_clock_in,
    input wire logic crystal_clock_input_in,
    // other interrupt sources (status bits 6..0, same clock)
    input wire logic [6:0] other_status_set_in,
    // outputs to the rate generator and counter/timer
    output logic baud_rate_set_out,
    output logic ct_timer_mode_out,
    output logic ct_square_wave_out,
    output logic ct_ready_out,
    // interrupt
    output logic interrupt_out_n
);
    // three-stage synchronisers for all asynchronous inputs
    localparam int sync_width = pin_count + 3;
    logic [sync_width-1:0] sync1, sync2, sync3;
    logic [sync_width-1:0] raw_pins;
    logic [sync_width-1:0] stable; // accepted level
    logic [sync_width-1:0] next_stable;
    logic [sync_width-1:0] changed; // accepted change this cycle

    assign raw_pins = {crystal_clock_input_in, chan_b_tx_1x_clock_in, chan_a_tx_1x_clock_in, input_pin_in};

    // a change counts once the second and third stages agree
    always_comb begin
        next_stable = stable;
        for (int i = 0; i < sync_width; i++) begin
            if (sync2[i] == sync3[i]) begin
                next_stable[i] = sync3[i];
            end
        end
        changed = next_stable ^ stable;
    end

    // synchroniser and accepted-level registers
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            stable <= '0;
        end else begin
            sync1 <= raw_pins;
            sync2 <= sync1;
            sync3 <= sync2;
            stable <= next_stable;
        end
    end

    // register state
    aux_fields_type aux, next_aux; // auxiliary control contents
    logic [pin_count-1:0] change_flag, next_change_flag; // input change flags
    logic [7:0] status, next_status; // interrupt status register
    logic [7:0] mask, next_mask; // interrupt mask register
    logic [7:0] next_read_data;
    logic next_irq_n;
    logic irq_n;
    logic wr_aux, rd_change, wr_status, wr_mask;
    logic ct_tick;
    logic ct_timer;
    logic [15:0] ct_count, next_ct_count;
    logic square, next_square;
    logic ready_evt; // counter reached terminal count

    // single decode used by both strobes
    function automatic logic hit(input logic [3:0] addr, input logic [3:0] offset);
        return addr == offset;
    endfunction

    // register access and interrupt next state
    always_comb begin
        wr_aux = write_strobe_in && hit(address_in, aux_control_offset);
        rd_change = read_strobe_in && hit(address_in, input_change_offset);
        wr_status = write_strobe_in && hit(address_in, status_offset);
        wr_mask = write_strobe_in && hit(address_in, mask_offset);
        next_aux = aux;
        if (wr_aux) begin
            next_aux = aux_fields_type'(write_data_in); // all eight bits at once
        end
        // reading clears the flags, a change in the same cycle still wins
        next_change_flag = rd_change ? '0 : change_flag;
        next_change_flag = next_change_flag | changed[pin_count-1:0];
        next_status = status;
        if (rd_change) begin
            next_status[input_change_status_bit] = 1'b0;
        end
        if (wr_status) begin
            next_status = next_status & ~write_data_in; // write one to clear
        end
        // only enabled pins reach status bit 7
        if (|(changed[pin_count-1:0] & aux.change_enable)) begin
            next_status[input_change_status_bit] = 1'b1;
        end
        next_status[6:0] = next_status[6:0] | other_status_set_in;
        if (ready_evt) begin
            next_status[3] = 1'b1; // counter ready
        end
        next_mask = wr_mask ? write_data_in : mask;
        next_irq_n = !(|(next_status & next_mask));
        // read data; the control register itself is write only
        case (address_in)
            input_change_offset: next_read_data = {change_flag, stable[pin_count-1:0]};
            status_offset: next_read_data = status;
            mask_offset: next_read_data = mask;
            default: next_read_data = 8'h00;
        endcase
        if (!read_strobe_in) begin
            next_read_data = 8'h00;
        end
    end

    // register file flip-flops
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            aux <= aux_fields_type'(aux_control_reset);
            change_flag <= '0;
            status <= status_reset;
            mask <= mask_reset;
            irq_n <= 1'b1;
            read_data_out <= 8'h00;
        end else begin
            aux <= next_aux;
            change_flag <= next_change_flag;
            status <= next_status;
            mask <= next_mask;
            irq_n <= next_irq_n;
            read_data_out <= next_read_data;
        end
    end

    // counter/timer tick source
    ct_clock_select ct_select (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .code_in(aux.ct_code),
        .pin2_edge_in(changed[2] && next_stable[2]),
        .tx_a_edge_in(changed[pin_count] && next_stable[pin_count]),
        .tx_b_edge_in(changed[pin_count+1] && next_stable[pin_count+1]),
        .xtal_edge_in(changed[pin_count+2] && next_stable[pin_count+2]),
        .tick_out(ct_tick),
        .timer_mode_out(ct_timer)
    );

    // counter counts down once; timer reloads and toggles a square wave
    always_comb begin
        next_ct_count = ct_count;
        next_square = square;
        ready_evt = 1'b0;
        if (ct_tick) begin
            if (ct_count == 16'h0001) begin
                ready_evt = 1'b1;
                if (ct_timer) begin
                    next_ct_count = ct_preload;
                    next_square = !square;
                end else begin
                    next_ct_count = 16'h0000; // one-shot stop
                end
            end else if (ct_count != 16'h0000 || ct_timer) begin
                next_ct_count = ct_count - 16'h0001;
            end
        end
    end

    // counter/timer registers
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            ct_count <= ct_preload;
            square <= 1'b0;
            ct_ready_out <= 1'b0;
            baud_rate_set_out <= 1'b0;
            ct_timer_mode_out <= 1'b0;
            ct_square_wave_out <= 1'b0;
        end else begin
            ct_count <= next_ct_count;
            square <= next_square;
            ct_ready_out <= ready_evt;
            baud_rate_set_out <= aux.baud_set; // one rate set for both channels
            ct_timer_mode_out <= ct_timer;
            ct_square_wave_out <= next_square && ct_timer;
        end
    end

    assign interrupt_out_n = irq_n;

    // assertions
    sequence aux_write_s;
        write_strobe_in && address_in == aux_control_offset;
    endsequence

    baud_set_follows_a: assert property (@(posedge clock_in) disable iff (reset_in)
        aux_write_s |=> ##1 baud_rate_set_out == $past(write_data_in[baud_set_bit], 2))
        else $error("baud set output does not follow write");
    aux_load_a: assert property (@(posedge clock_in) disable iff (reset_in)
        aux_write_s |=> aux == $past(write_data_in))
        else $error("control register not loaded");
    enabled_change_a: assert property (@(posedge clock_in) disable iff (reset_in)
        |(changed[pin_count-1:0] & aux.change_enable) |=> status[input_change_status_bit])
        else $error("enabled change did not set status bit 7");
    disabled_change_a: assert property (@(posedge clock_in) disable iff (reset_in)
        (!status[7] && !(|(changed[pin_count-1:0] & aux.change_enable))) |=> !status[7])
        else $error("status bit 7 set without enabled change");
    read_clears_a: assert property (@(posedge clock_in) disable iff (reset_in)
        (rd_change && !(|changed[pin_count-1:0])) |=> change_flag == '0)
        else $error("read did not clear change flags");
    irq_mask_a: assert property (@(posedge clock_in) disable iff (reset_in)
        (status[7] && !mask[7] && !(|(status[6:0] & mask[6:0]))) |-> interrupt_out_n)
        else $error("interrupt asserted with bit 7 masked");
    irq_level_a: assert property (@(posedge clock_in) disable iff (reset_in)
        (|(status & mask)) |-> !interrupt_out_n)
        else $error("interrupt not asserted for unmasked status");
    timer_mode_a: assert property (@(posedge clock_in) disable iff (reset_in)
        aux_write_s |=> ##1 ct_timer_mode_out == $past(write_data_in[ct_timer_bit], 2))
        else $error("timer mode does not follow field");
    counter_flat_a: assert property (@(posedge clock_in) disable iff (reset_in)
        !ct_timer |=> !ct_square_wave_out)
        else $error("square wave in counter mode");
endmodule // aux_control_register

//--- rtl/aux_control_pkg.sv
// Function
// - bit 7 picks the baud-rate set
// - selected set offered to both channels
// - bits 6..4 set timer mode and clock
// - codes 000..011 counter, listed clock sources
// - codes 100..111 timer, listed clock sources
// - timer mode makes a square wave
// - enabled change flag sets status bit 7
// - status bit 7 interrupts only when mask bit 7 is one
// - disabled pin leaves status bit 7 alone
// - flags set on change, cleared by read
// - interrupt low while any status bit and its mask bit are both one
package aux_control_pkg;
    // register offsets
    localparam logic [3:0] aux_control_offset = 4'h4; // write side of the shared address
    localparam logic [3:0] input_change_offset = 4'h4; // read side of the shared address
    localparam logic [3:0] status_offset = 4'h5;
    localparam logic [3:0] mask_offset = 4'h6; // no offset given, taken the next free one
    // field positions
    localparam int baud_set_bit = 7;
    localparam int ct_mode_lsb = 4;
    localparam int ct_timer_bit = 6;
    localparam int input_change_status_bit = 7;
    // reset values
    localparam logic [7:0] aux_control_reset = 8'h00;
    localparam logic [7:0] status_reset = 8'h00;
    localparam logic [7:0] mask_reset = 8'h00;
    // prescaler for the divided clock sources
    localparam logic [3:0] prescale_last = 4'hf;

    // counter/timer source codes
    typedef enum logic [2:0] {
        ct_count_pin2 = 3'h0,
        ct_count_tx_a = 3'h1,
        ct_count_tx_b = 3'h2,
        ct_count_xtal16 = 3'h3,
        ct_timer_pin2 = 3'h4,
        ct_timer_pin2_16 = 3'h5,
        ct_timer_xtal = 3'h6,
        ct_timer_xtal16 = 3'h7
    } ct_code_type;

    // decoded auxiliary control fields
    typedef struct packed {
        logic baud_set;
        ct_code_type ct_code;
        logic [3:0] change_enable;
    } aux_fields_type;
endpackage

//--- rtl/ct_clock_select.sv
`timescale 1ns/1ps
// picks the counter/timer tick from the synchronised sources per mode code
module ct_clock_select
    import aux_control_pkg::*;
(
    // clock and reset
    input wire logic clock_in,
    input wire logic reset_in,
    // mode code and source edges (one-cycle pulses)
    input wire logic [2:0] code_in,
    input wire logic pin2_edge_in,
    input wire logic tx_a_edge_in,
    input wire logic tx_b_edge_in,
    input wire logic xtal_edge_in,
    // selected tick
    output logic tick_out,
    output logic timer_mode_out
);
    logic [3:0] prescale; // shared divide-by-16 counter
    logic [3:0] next_prescale;
    logic raw_edge; // undivided source edge
    logic divide; // code wants divide by 16
    logic next_tick;
    logic tick;

    // source choice and prescaler next state
    always_comb begin
        raw_edge = 1'b0;
        divide = 1'b0;
        case (ct_code_type'(code_in))
            ct_count_pin2: raw_edge = pin2_edge_in;
            ct_count_tx_a: raw_edge = tx_a_edge_in;
            ct_count_tx_b: raw_edge = tx_b_edge_in;
            ct_count_xtal16: begin
                raw_edge = xtal_edge_in;
                divide = 1'b1;
            end
            ct_timer_pin2: raw_edge = pin2_edge_in;
            ct_timer_pin2_16: begin
                raw_edge = pin2_edge_in;
                divide = 1'b1;
            end
            ct_timer_xtal: raw_edge = xtal_edge_in;
            ct_timer_xtal16: begin
                raw_edge = xtal_edge_in;
                divide = 1'b1;
            end
            default: raw_edge = 1'b0;
        endcase
        next_prescale = prescale;
        if (raw_edge) begin
            next_prescale = prescale + 4'h1; // wraps after sixteen edges
        end
        next_tick = raw_edge && (!divide || prescale == prescale_last);
    end

    // registers
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            prescale <= 4'h0;
            tick <= 1'b0;
        end else begin
            prescale <= next_prescale;
            tick <= next_tick;
        end
    end

    assign tick_out = tick;
    assign timer_mode_out = code_in[2];

    // divided sources fire once per sixteen edges only
    div_tick_a: assert property (@(posedge clock_in) disable iff (reset_in)
        (divide && raw_edge && prescale != prescale_last) |=> !tick)
        else $error("divided source ticked early");
endmodule // ct_clock_select

//--- bench/aux_control_register_tb_top.sv
`timescale 1ns/1ps
// self-checking bench for the auxiliary control register, driven straight at its ports
module aux_control_register_tb_top;
    import aux_control_pkg::*;
    // stimulus, all given a value at time zero
    logic clock_in = 1'b0;
    logic reset_in = 1'b1;
    logic [3:0] address_in = 4'h0;
    logic [7:0] write_data_in = 8'h00;
    logic write_strobe_in = 1'b0;
    logic read_strobe_in = 1'b0;
    logic [3:0] input_pin_in = 4'h0; // pin 2 stays still so the counter never ticks by surprise
    logic chan_a_tx_1x_clock_in = 1'b0;
    logic chan_b_tx_1x_clock_in = 1'b0;
    logic crystal_clock_input_in = 1'b0;
    logic [6:0] other_status_set_in = 7'h00;
    // design outputs
    logic [7:0] read_data_out;
    logic baud_rate_set_out;
    logic ct_timer_mode_out;
    logic ct_square_wave_out;
    logic ct_ready_out;
    logic interrupt_out_n;
    // bookkeeping
    int err_count = 0;
    int tests_run = 0;
    logic [7:0] exp_q[$]; // expected read data, oldest first
    string name_q[$];
    logic read_seen = 1'b0; // read strobe was taken at the last edge
    logic sources_run = 1'b0; // clock sources toggle only while a timer test wants them
    logic [1:0] source_div = 2'h0; // holds each source level four cycles so the synchroniser can accept it
    logic [31:0] rnd;
    int i;

    // short preload keeps the square-wave period to a few dozen cycles
    aux_control_register #(.pin_count(4), .ct_preload(16'h0004)) dut (
        .clock_in, .reset_in, .address_in, .write_data_in, .write_strobe_in, .read_strobe_in,
        .read_data_out, .input_pin_in, .chan_a_tx_1x_clock_in, .chan_b_tx_1x_clock_in,
        .crystal_clock_input_in, .other_status_set_in, .baud_rate_set_out, .ct_timer_mode_out,
        .ct_square_wave_out, .ct_ready_out, .interrupt_out_n
    );

    // 250 MHz clock
    always #2 clock_in = ~clock_in;

    // source clocks at an eighth of the system rate, and note of each taken read
    // a level that flips every cycle never lets the second and third stages agree, so it would never count
    always @(posedge clock_in) begin
        if (sources_run) begin
            source_div <= source_div + 2'h1;
            if (source_div == 2'h3) begin
                crystal_clock_input_in <= ~crystal_clock_input_in;
                chan_a_tx_1x_clock_in <= ~chan_a_tx_1x_clock_in;
                chan_b_tx_1x_clock_in <= ~chan_b_tx_1x_clock_in;
            end
        end
        read_seen <= read_strobe_in;
    end

    // read data stand in the cycle after the strobe only, so look mid-cycle
    always @(negedge clock_in) begin
        if (read_seen) begin
            if (exp_q.size() == 0) begin
                err_count++;
                $display("Error read_data_out expected none seen %h", read_data_out);
            end else begin
                check(name_q.pop_front(), exp_q.pop_front(), read_data_out);
            end
        end
    end

    // one comparison, case equality so unknowns never match
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one-cycle write, then an idle cycle so the strobe is never assigned twice in a step
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        address_in <= a;
        write_data_in <= d;
        write_strobe_in <= 1'b1;
        @(posedge clock_in);
        write_strobe_in <= 1'b0;
        @(posedge clock_in);
    endtask

    // one-cycle read; the expectation goes to the queue for the watcher
    task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
        address_in <= a;
        read_strobe_in <= 1'b1;
        exp_q.push_back(exp);
        name_q.push_back(what);
        @(posedge clock_in);
        read_strobe_in <= 1'b0;
        @(posedge clock_in);
    endtask

    // bounded wait for the interrupt level; running out ends the run
    task automatic wait_irq(input logic exp);
        for (i = 0; i < 40; i++) begin
            @(negedge clock_in);
            if (interrupt_out_n === exp) break;
        end
        check("interrupt_out_n", {7'h00, exp}, {7'h00, interrupt_out_n});
        if (interrupt_out_n !== exp) tally_and_finish();
        @(posedge clock_in);
    endtask

    // the single closing point of the run
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        rnd = $urandom(32'h87bf);
        repeat (8) @(posedge clock_in);
        reset_in <= 1'b0;
        @(posedge clock_in);
        @(negedge clock_in);
        check("baud set after reset", 8'h00, {7'h00, baud_rate_set_out});
        check("interrupt after reset", 8'h01, {7'h00, interrupt_out_n});
        @(posedge clock_in);
        rd(4'h5, status_reset, "status after reset");
        rd(4'ha, 8'h00, "unmapped read");
        // every mode code, with a random baud set bit beside it
        for (int c = 0; c < 8; c++) begin
            rnd = $urandom;
            wr(aux_control_offset, {rnd[0], c[2:0], 4'h0});
            @(negedge clock_in);
            check("baud set", {7'h00, rnd[0]}, {7'h00, baud_rate_set_out});
            check("timer mode", {7'h00, c[2]}, {7'h00, ct_timer_mode_out});
            check("square idle", 8'h00, {7'h00, ct_square_wave_out});
            @(posedge clock_in);
        end
        // timer on the crystal clock must give a square wave that rises and falls
        wr(aux_control_offset, 8'h60);
        sources_run <= 1'b1;
        for (int level = 1; level >= 0; level--) begin
            for (i = 0; i < 300; i++) begin
                @(negedge clock_in);
                if (ct_square_wave_out === level[0]) break;
            end
            check("square wave", {7'h00, level[0]}, {7'h00, ct_square_wave_out});
            check("counter ready pulse", 8'h01, {7'h00, ct_ready_out});
            if (ct_square_wave_out !== level[0]) tally_and_finish();
        end
        @(posedge clock_in);
        sources_run <= 1'b0;
        wr(aux_control_offset, 8'h00);
        @(negedge clock_in);
        check("square in counter mode", 8'h00, {7'h00, ct_square_wave_out});
        @(posedge clock_in);
        rd(status_offset, 8'h08, "counter ready status");
        wr(status_offset, 8'hff);
        rd(status_offset, 8'h00, "status cleared");
        // random other sources, with only bit 0 unmasked, drive the interrupt
        rnd = $urandom;
        other_status_set_in <= rnd[6:0] | 7'h01;
        @(posedge clock_in);
        other_status_set_in <= 7'h00;
        @(posedge clock_in);
        rd(status_offset, {1'b0, rnd[6:0] | 7'h01}, "other status");
        wr(mask_offset, 8'h01);
        wait_irq(1'b0);
        wr(status_offset, 8'h7f);
        wait_irq(1'b1);
        // enabled pin 0 change with mask bit 7 set
        wr(mask_offset, 8'h80);
        wr(aux_control_offset, 8'h01);
        input_pin_in <= 4'h1;
        wait_irq(1'b0);
        rd(status_offset, 8'h80, "status change bit");
        rd(input_change_offset, 8'h11, "change flags pin 0");
        rd(status_offset, 8'h00, "status after flag read");
        wait_irq(1'b1);
        // disabled pin 1 change leaves the status alone
        input_pin_in <= 4'h3;
        repeat (20) @(posedge clock_in);
        @(negedge clock_in);
        check("interrupt disabled pin", 8'h01, {7'h00, interrupt_out_n});
        @(posedge clock_in);
        rd(status_offset, 8'h00, "status disabled pin");
        rd(input_change_offset, 8'h23, "change flags pin 1");
        // enabled pin 0 falls with mask bit 7 clear: status sets, no interrupt
        wr(mask_offset, 8'h00);
        input_pin_in <= 4'h2;
        repeat (20) @(posedge clock_in);
        @(negedge clock_in);
        check("interrupt masked", 8'h01, {7'h00, interrupt_out_n});
        @(posedge clock_in);
        rd(status_offset, 8'h80, "status masked change");
        rd(input_change_offset, 8'h12, "change flags fall");
        rd(status_offset, 8'h00, "status after second read");
        repeat (2) @(posedge clock_in);
        tally_and_finish();
    end
endmodule // aux_control_register_tb_top
